/* shared/ppi_pkg.sv */
package ppi_pkg;

	localparam logic [1:0] LOC_FIRST  = 2'h0;
	localparam logic [1:0] LOC_SECOND = 2'h1;
	localparam logic [1:0] LOC_SPLIT  = 2'h2;
	localparam logic [1:0] LOC_CTRL   = 2'h3;

	localparam int CMD_TYPE_POS  = 7;
	localparam int FIRST_DIR_POS = 4;
	localparam int UPPER_DIR_POS = 3;
	localparam int SECOND_MODE_POS = 2;
	localparam int SECOND_DIR_POS = 1;
	localparam int LOWER_DIR_POS = 0;
	localparam int FIRST_MODE_LO = 5;
	localparam int BIT_VAL_POS   = 0;
	localparam int BIT_SEL_LO    = 1;
	localparam int MASK_FIRST_BIT  = 4;
	localparam int MASK_SECOND_BIT = 2;

	// All ports input, basic mode.
	localparam logic [7:0] MODE_RESET = 8'h9b;

	typedef struct packed {
		logic       cmd_type;
		logic [1:0] first_mode;
		logic       first_dir;
		logic       upper_dir;
		logic       second_mode;
		logic       second_dir;
		logic       lower_dir;
	} mode_word_s;

endpackage : ppi_pkg

/* verilog/ppi_core.sv */
module ppi_core
(
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       resetn,
	// Host bus
	input  wire logic       cs_n,
	input  wire logic       rd_n,
	input  wire logic       wr_n,
	input  wire logic       location_select_hi,
	input  wire logic       location_select_lo,
	input  wire logic [7:0] data_in,
	output logic      [7:0] data_out,
	output logic            data_oe,
	// Port pins
	input  wire logic [7:0] first_in,
	output logic      [7:0] first_out,
	output logic      [7:0] first_oe,
	input  wire logic [7:0] second_in,
	output logic      [7:0] second_out,
	output logic      [7:0] second_oe,
	input  wire logic [7:0] split_in,
	output logic      [7:0] split_out,
	output logic      [7:0] split_oe,
	// Gated service requests
	output logic            service_request_out_first,
	output logic            service_request_out_second
);

	////////////////////////////////////////////////////////////////////////////
	// Pin and bus synchronisers. Every asynchronous input passes two flops.

	logic [7:0]  first_s1_q, first_s2_q, second_s1_q, second_s2_q, split_s1_q, split_s2_q;
	logic [7:0]  din_s1_q, din_s2_q;
	logic [4:0]  ctl_s1_q, ctl_s2_q;

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			first_s1_q  <= 8'hff;
			first_s2_q  <= 8'hff;
			second_s1_q <= 8'hff;
			second_s2_q <= 8'hff;
			split_s1_q  <= 8'hff;
			split_s2_q  <= 8'hff;
			din_s1_q    <= 8'h00;
			din_s2_q    <= 8'h00;
			ctl_s1_q    <= 5'h07;
			ctl_s2_q    <= 5'h07;
		end
		else
		begin
			first_s1_q  <= first_in;
			first_s2_q  <= first_s1_q;
			second_s1_q <= second_in;
			second_s2_q <= second_s1_q;
			split_s1_q  <= split_in;
			split_s2_q  <= split_s1_q;
			din_s1_q    <= data_in;
			din_s2_q    <= din_s1_q;
			ctl_s1_q    <= {location_select_hi, location_select_lo, cs_n, rd_n, wr_n};
			ctl_s2_q    <= ctl_s1_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Bus decode.

	wire [1:0] loc     = ctl_s2_q[4:3];
	wire       sel     = !ctl_s2_q[2];
	wire       rd_act  = sel && !ctl_s2_q[1] && ctl_s2_q[0];
	wire       wr_act  = sel && !ctl_s2_q[0] && ctl_s2_q[1];
	logic      wr_prev_q;
	// Writes are taken once, on the leading edge of the strobe, after data settled.
	wire       wr_take = wr_act && !wr_prev_q;

	logic [7:0] mode_q, mode_d;
	logic [7:0] first_lat_q, first_lat_d, second_lat_q, second_lat_d;
	logic [7:0] split_lat_q, split_lat_d;
	logic       mask_first_q, mask_first_d, mask_second_q, mask_second_d;
	logic [7:0] first_inlat_q;

	ppi_pkg::mode_word_s mw;
	assign mw = ppi_pkg::mode_word_s'(mode_q);

	wire is_mode_wr = wr_take && (loc == ppi_pkg::LOC_CTRL) && din_s2_q[ppi_pkg::CMD_TYPE_POS];
	wire is_bit_wr  = wr_take && (loc == ppi_pkg::LOC_CTRL) && !din_s2_q[ppi_pkg::CMD_TYPE_POS];
	wire [2:0] bit_sel = din_s2_q[ppi_pkg::BIT_SEL_LO +: 3];
	wire       bit_val = din_s2_q[ppi_pkg::BIT_VAL_POS];

	// Group modes: first group may be 0, 1 or 2; second group only 0 or 1.
	wire first_m0 = (mw.first_mode == 2'h0);
	wire first_m2 = mw.first_mode[1];
	wire second_m0 = !mw.second_mode;

	////////////////////////////////////////////////////////////////////////////
	// Direction per pin group; a one in a direction bit means input.

	wire first_is_out = !mw.first_dir && !first_m2;
	wire second_is_out = !mw.second_dir;
	wire [3:0] upper_oe = mw.upper_dir ? 4'h0 : 4'hf;
	wire [3:0] lower_oe = mw.lower_dir ? 4'h0 : 4'hf;
	// Handshake lines of strobed modes are not generated; here the halves keep
	// their basic direction so that the latch stays reachable by bit commands.
	wire [7:0] split_oe_w = {upper_oe, lower_oe};

	////////////////////////////////////////////////////////////////////////////
	// Next-state logic for latches and masks.

	always_comb
	begin
		mode_d        = mode_q;
		first_lat_d   = first_lat_q;
		second_lat_d  = second_lat_q;
		split_lat_d   = split_lat_q;
		mask_first_d  = mask_first_q;
		mask_second_d = mask_second_q;
		if (is_mode_wr)
		begin
			mode_d        = din_s2_q;
			first_lat_d   = 8'h00;
			second_lat_d  = 8'h00;
			split_lat_d   = 8'h00;
			mask_first_d  = 1'b0;
			mask_second_d = 1'b0;
		end
		else if (is_bit_wr)
		begin
			split_lat_d[bit_sel] = bit_val;
			if (bit_sel == 3'(ppi_pkg::MASK_FIRST_BIT))
				mask_first_d = bit_val;
			if (bit_sel == 3'(ppi_pkg::MASK_SECOND_BIT))
				mask_second_d = bit_val;
		end
		else if (wr_take)
		begin
			unique case (loc)
				ppi_pkg::LOC_FIRST:  first_lat_d  = din_s2_q;
				ppi_pkg::LOC_SECOND: second_lat_d = din_s2_q;
				ppi_pkg::LOC_SPLIT:  split_lat_d  = din_s2_q;
				ppi_pkg::LOC_CTRL:   split_lat_d  = split_lat_q;
			endcase
		end
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			mode_q        <= ppi_pkg::MODE_RESET;
			// Latches come up at one so that the port outputs match the held pin level.
			first_lat_q   <= 8'hff;
			second_lat_q  <= 8'hff;
			split_lat_q   <= 8'hff;
			mask_first_q  <= 1'b0;
			mask_second_q <= 1'b0;
			wr_prev_q     <= 1'b0;
		end
		else
		begin
			mode_q        <= mode_d;
			first_lat_q   <= first_lat_d;
			second_lat_q  <= second_lat_d;
			split_lat_q   <= split_lat_d;
			mask_first_q  <= mask_first_d;
			mask_second_q <= mask_second_d;
			wr_prev_q     <= wr_act;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// First port input latch: in basic mode it follows the pins, otherwise it
	// follows them except while a read of any location is active, when it holds.

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			first_inlat_q <= 8'hff;
		else if (first_m0)
			first_inlat_q <= first_s2_q;
		else if (!rd_act)
			first_inlat_q <= first_s2_q;
	end

	////////////////////////////////////////////////////////////////////////////
	// Read path.

	wire [7:0] split_rd = (split_lat_q & split_oe_w) | (split_s2_q & ~split_oe_w);
	wire [7:0] mode_rd  = {1'b1, mode_q[6:0]};
	wire [7:0] first_rd = first_is_out ? first_lat_q : first_inlat_q;
	wire [7:0] second_rd = second_is_out ? second_lat_q : second_s2_q;

	logic [7:0] rd_mux;
	always_comb
	begin
		unique case (loc)
			ppi_pkg::LOC_FIRST:  rd_mux = first_rd;
			ppi_pkg::LOC_SECOND: rd_mux = second_rd;
			ppi_pkg::LOC_SPLIT:  rd_mux = split_rd;
			ppi_pkg::LOC_CTRL:   rd_mux = mode_rd;
		endcase
	end

	// Strobed-mode requests are gated by their masks; basic mode raises none.
	wire req_first  = !first_m0 && mask_first_q && split_lat_q[3];
	wire req_second = !second_m0 && mask_second_q && split_lat_q[0];

	////////////////////////////////////////////////////////////////////////////
	// Output registers.

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			data_out   <= 8'h00;
			data_oe    <= 1'b0;
			first_out  <= 8'hff;
			first_oe   <= 8'h00;
			second_out <= 8'hff;
			second_oe  <= 8'h00;
			split_out  <= 8'hff;
			split_oe   <= 8'h00;
			service_request_out_first  <= 1'b0;
			service_request_out_second <= 1'b0;
		end
		else
		begin
			data_out   <= rd_mux;
			data_oe    <= rd_act;
			first_out  <= first_lat_q;
			first_oe   <= first_is_out ? 8'hff : 8'h00;
			second_out <= second_lat_q;
			second_oe  <= second_is_out ? 8'hff : 8'h00;
			split_out  <= split_lat_q;
			split_oe   <= split_oe_w;
			service_request_out_first  <= req_first;
			service_request_out_second <= req_second;
		end
	end

endmodule : ppi_core

/* tb/ppi_core_props.sv */
module ppi_core_props
(
	// Clock, reset and host bus
	input wire logic       clk,
	input wire logic       resetn,
	input wire logic       cs_n,
	input wire logic       rd_n,
	input wire logic       wr_n,
	input wire logic       location_select_hi,
	input wire logic       location_select_lo,
	input wire logic [7:0] data_in,
	input wire logic [7:0] data_out,
	input wire logic       data_oe,
	// Port side
	input wire logic [7:0] first_out,
	input wire logic [7:0] first_oe,
	input wire logic [7:0] split_out,
	input wire logic       service_request_out_first,
	input wire logic       service_request_out_second
);
	wire       rd  = !cs_n && !rd_n && wr_n;
	wire       wr  = !cs_n && !wr_n && rd_n;
	wire [1:0] loc = {location_select_hi, location_select_lo};
	wire       req = service_request_out_first || service_request_out_second;
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	////////////////////////////////////////////////////////////////
	// Strobes pass a two-flop synchroniser, so every strobe check waits that latency out.
	sequence ctl_wr_s;
		(wr && loc == 2'h3)[*7];
	endsequence
	a_idle_float: assert property (cs_n[*5] |-> !data_oe)
		else $error("bus driven while deselected");
	a_strobes_idle: assert property ((rd_n && wr_n)[*5] |-> !data_oe)
		else $error("bus driven without strobe");
	a_read_drives: assert property (rd[*6] |-> data_oe)
		else $error("bus not driven during read");
	a_ctrl_bit7: assert property ((rd && loc == 2'h3)[*6] |-> data_out[7])
		else $error("control read bit 7 low");
	a_reset_inputs: assert property ($rose(resetn) |-> first_oe == 8'h00 && !req)
		else $error("port driven out of reset");
	a_mode_clears: assert property (ctl_wr_s ##0 data_in[7] |->
		first_out == 8'h00 && split_out == 8'h00 && !req)
		else $error("mode write left outputs set");
	a_bit_cmd: assert property (ctl_wr_s ##0 !data_in[7] |->
		split_out[data_in[3:1]] == data_in[0])
		else $error("single bit command not applied");
	a_first_write: assert property ((wr && loc == 2'h0)[*7] |-> first_out == data_in)
		else $error("first port latch not written");
endmodule : ppi_core_props

bind ppi_core ppi_core_props u_props (.*);

/* tb/ppi_host.sv */
module ppi_host
(
	// Device answer
	input  wire logic       clk,
	input  wire logic [7:0] data_out,
	input  wire logic       data_oe,
	// Host strobes and data
	output logic            cs_n,
	output logic            rd_n,
	output logic            wr_n,
	output logic      [1:0] loc,
	output logic      [7:0] data_in
);
	timeunit 1ns;
	timeprecision 1ps;
	initial {cs_n, rd_n, wr_n, loc, data_in} = 13'h1c00;
	// Data is set up three cycles early because the device samples it through flops.
	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		@(negedge clk) {loc, data_in, cs_n} <= {a, d, 1'b0};
		repeat (3) @(negedge clk);
		wr_n <= 1'b0;
		repeat (8) @(negedge clk);
		wr_n <= 1'b1;
		repeat (4) @(negedge clk);
		{cs_n, data_in} <= {1'b1, ~d};
	endtask : wr
	task automatic rd(input logic [1:0] a, output logic [7:0] d, output bit ok);
		@(negedge clk) {loc, cs_n, rd_n} <= {a, 2'b00};
		for (int n = 0; n < 12 && data_oe !== 1'b1; n++) @(negedge clk);
		ok = data_oe === 1'b1;
		d = data_out;
		repeat (3) @(negedge clk);
		{cs_n, rd_n} <= 2'b11;
		repeat (4) @(negedge clk);
	endtask : rd
endmodule : ppi_host

/* tb/programmable_parallel_io_control_test.sv */
module programmable_parallel_io_control_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic       clk = 1'b0;
	logic       resetn = 1'b0;
	logic       cs_n, rd_n, wr_n, data_oe, service_request_out_first, service_request_out_second;
	logic [1:0] loc;
	logic [7:0] data_in, data_out, first_in, second_in, split_in, first_out, second_out, split_out;
	logic [7:0] first_oe, second_oe, split_oe, d;
	logic [7:0] pins [3], outs [3], oes [3], lat [3];
	int         mismatches = 0, total_checks = 0, seed = 62572, m;
	bit         ok;
	assign pins = '{first_in, second_in, split_in};
	assign outs = '{first_out, second_out, split_out};
	assign oes  = '{first_oe, second_oe, split_oe};
	always #2.5 clk = ~clk;
	ppi_core uut (.*, .location_select_hi(loc[1]), .location_select_lo(loc[0]));
	ppi_host host (.*);
	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic finish_test;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : finish_test
	function automatic logic [7:0] dmask(int p);
		return p == 0 ? {8{m[4]}} : p == 1 ? {8{m[1]}} : {{4{m[3]}}, {4{m[0]}}};
	endfunction : dmask
	task automatic rdchk(int p);
		logic [7:0] v;
		host.rd(2'(p), v, ok);
		if (!ok)
		begin
			mismatches++;
			finish_test();
		end
		chk(v, p == 3 ? 8'(m) | 8'h80 : (pins[p] & dmask(p)) | (lat[p] & ~dmask(p)));
	endtask : rdchk
	initial
	begin
		{first_in, second_in, split_in} = 24'($random(seed));
		m = 8'h9b;
		lat = '{default: 8'hff};
		repeat (5) @(negedge clk);
		resetn = 1'b1;
		repeat (3) @(negedge clk);
		for (int p = 0; p < 3; p++) chk(oes[p] | ~outs[p], 8'h00);
		rdchk(3);
		repeat (4)
		begin
			m = 8'h80 | ($random(seed) & 8'h1b);
			host.wr(2'h3, 8'(m));
			lat = '{default: 8'h00};
			{first_in, second_in, split_in} = 24'($random(seed));
			for (int p = 0; p < 3; p++)
			begin
				chk(outs[p], 8'h00);
				chk(oes[p], ~dmask(p));
				d = 8'($random(seed));
				host.wr(2'(p), d);
				lat[p] = d;
				chk(outs[p], lat[p]);
				rdchk(p);
			end
			d = 8'($random(seed));
			host.wr(2'h3, {4'h0, d[2:0], d[3]});
			lat[2][d[2:0]] = d[3];
			chk(split_out, lat[2]);
			rdchk(3);
		end
		m = 8'ha4;
		host.wr(2'h3, 8'ha4);
		host.wr(2'h3, 8'h07);
		host.wr(2'h3, 8'h01);
		chk({6'h00, service_request_out_first, service_request_out_second}, 8'h00);
		host.wr(2'h3, 8'h09);
		host.wr(2'h3, 8'h05);
		chk({6'h00, service_request_out_first, service_request_out_second}, 8'h03);
		host.wr(2'h3, 8'ha4);
		chk({6'h00, service_request_out_first, service_request_out_second}, 8'h00);
		finish_test();
	end
endmodule : programmable_parallel_io_control_test
